/* dmba_arbiter.sv */
/*
 Data memory bus arbiter (extended data space included) for three
 masters: processor core, DMA controller and debug module master.
 Assumes each master holds req high until its access completes and
 signals completion with a one-cycle done pulse while granted.
 Assumes all masters and the register bus run on clk and share the
 synchronous reset, so no request needs a synchroniser.
 Register bus: a request is taken on the edge where cyc and stb are
 high and no ack is pending; ack and read data follow one edge later;
 ack stands for exactly one cycle, read data until the next request.
 Masters: a grant appears one edge after the request is seen while the
 bus is free, stands until the owner's done pulse, and drops for one
 idle cycle before the next winner is chosen.
 Any priority value other than the raised encoding ranks as default.
*/
// Operation
// - Arbitrate data memory among core, DMA, debug
// - Grant highest requester, suspend others until done
// - Default: core M0, DMA M3, debug M4
// - Slots M1 and M2 unused by default
// - At 0x0020: DMA, then core, then debug
// - Raised masters keep their mutual order
// - Lowered masters keep their mutual order
// - Priority changes apply live, no reset
`timescale 1ns/1ns
`default_nettype none

module dmba_arbiter (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [3:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output var  logic [31:0] wbDatR,
   output var  logic        wbAck,
   // Master requests (held until granted and done)
   input  wire logic [2:0]  mstReq,
   input  wire logic [2:0]  mstDone,
   // Grant to the data memory bus, one-hot
   output var  logic [2:0]  mstGnt
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      dmba_pkg::dmba_state_t st;      // Bus owned or free
      logic [2:0]            gnt;     // One-hot grant
      logic [15:0]           prio;    // Priority control register
      logic                  ack;     // Wishbone ack
      logic [31:0]           rdat;    // Read data
   } dmba_regs_t;

   dmba_regs_t r_reg;  // Registered state
   dmba_regs_t r_next; // Next state

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Picks the winner; slots M1/M2 never hold a master by default.
   // Reserved settings fall back to the default ranking.
   function automatic logic [2:0] pick(input logic [2:0]  req,
                                       input logic [15:0] prio);
      logic [2:0] g;
      g = 3'h0;
      if (prio == dmba_pkg::PRIO_DMA_RAISED) begin
         if (req[dmba_pkg::MST_DMA])        g = 3'h2;
         else if (req[dmba_pkg::MST_CORE])  g = 3'h1;
         else if (req[dmba_pkg::MST_DEBUG]) g = 3'h4;
      end else begin
         if (req[dmba_pkg::MST_CORE])       g = 3'h1;
         else if (req[dmba_pkg::MST_DMA])   g = 3'h2;
         else if (req[dmba_pkg::MST_DEBUG]) g = 3'h4;
      end
      return g;
   endfunction : pick

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] dat,
                                         input logic [1:0]  sel);
      logic [15:0] m;
      m = old;
      if (sel[0]) m[7:0]  = dat[7:0];
      if (sel[1]) m[15:8] = dat[15:8];
      return m;
   endfunction : merge

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   // A request already answered is not taken a second time
   logic wbReq;   // New bus request this cycle
   logic prioHit; // Address selects the priority control register
   logic statHit; // Address selects the grant status register
   assign wbReq   = wbCyc && wbStb && !r_reg.ack;
   assign prioHit = wbAdr == dmba_pkg::PRIO_CTRL_OFFSET;
   assign statHit = wbAdr == dmba_pkg::STATUS_OFFSET;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Register access and arbitration decide the next state together
   always_comb begin
      r_next = r_reg;
      r_next.ack = wbReq;
      // Register access
      if (wbReq) begin
         r_next.rdat = dmba_pkg::UNMAPPED_READ;
         if (prioHit) begin // Priority control: read back, write lanes
            r_next.rdat = {16'h0000, r_reg.prio};
            if (wbWe) begin // stored as written
               r_next.prio = merge(r_reg.prio, wbDatW[15:0], wbSel[1:0]);
            end
         end else if (statHit) begin // Grant status: requests and owner
            r_next.rdat = {24'h000000, mstReq, 2'h0, r_reg.gnt};
         end
      end
      // Arbitration
      case (r_reg.st)
         dmba_pkg::ARB_IDLE: begin
            r_next.gnt = pick(mstReq, r_reg.prio);
            if (r_next.gnt != 3'h0) r_next.st = dmba_pkg::ARB_BUSY;
         end
         dmba_pkg::ARB_BUSY: begin
            // Others stay suspended until the owner finishes
            if ((mstDone & r_reg.gnt) != 3'h0) begin
               r_next.gnt = 3'h0;
               r_next.st  = dmba_pkg::ARB_IDLE;
            end
         end
         default: begin
            r_next.gnt = 3'h0;
            r_next.st  = dmba_pkg::ARB_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Synchronous reset clears grant, ack, read data and priority
   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg.st   <= dmba_pkg::ARB_IDLE;
         r_reg.gnt  <= 3'h0;
         r_reg.prio <= dmba_pkg::PRIO_CTRL_RESET;
         r_reg.ack  <= 1'b0;
         r_reg.rdat <= 32'h00000000;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from flip-flops
   assign mstGnt = r_reg.gnt;
   assign wbAck  = r_reg.ack;
   assign wbDatR = r_reg.rdat;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   one_grant_a: assert property (@(posedge clk) disable iff (!rstn)
      $onehot0(mstGnt)) else $error("more than one grant");

   grant_held_a: assert property (@(posedge clk) disable iff (!rstn)
      (mstGnt != 3'h0 && (mstDone & mstGnt) == 3'h0) |=> $stable(mstGnt))
      else $error("grant changed before done");

   core_first_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && r_reg.prio == dmba_pkg::PRIO_DEFAULT
       && mstReq[0]) |=> mstGnt == 3'h1)
      else $error("core not granted first by default");

   dma_first_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE
       && r_reg.prio == dmba_pkg::PRIO_DMA_RAISED
       && mstReq[1]) |=> mstGnt == 3'h2)
      else $error("dma not granted first when raised");

   dma_over_dbg_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && mstReq == 3'h6)
      |=> mstGnt == 3'h2) else $error("debug beat dma");

   core_over_dbg_a: assert property (@(posedge clk)
      disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && mstReq == 3'h5)
      |=> mstGnt == 3'h1) else $error("debug beat core");

   grant_soon_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && mstReq != 3'h0)
      |=> mstGnt != 3'h0) else $error("request not granted");

   prio_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (wbReq && wbWe && prioHit && wbSel[1:0] == 2'h3)
      |=> r_reg.prio == $past(wbDatW[15:0]))
      else $error("priority write lost");

   slots_a: assert property (@(posedge clk) disable iff (!rstn)
      mstGnt[2] |-> $past(r_reg.st == dmba_pkg::ARB_BUSY
                          || mstReq[1:0] == 2'h0))
      else $error("debug granted over higher master");

   ack_once_a: assert property (@(posedge clk) disable iff (!rstn)
      wbAck |=> !wbAck) else $error("ack longer than a cycle");

   // ----------------------------------------------------------------
   // Register bus checks
   // ----------------------------------------------------------------
   // A taken request is answered on the very next edge
   ack_follows_a: assert property (@(posedge clk) disable iff (!rstn)
      wbReq |=> wbAck) else $error("request not acknowledged");

   // No acknowledge appears without a taken request
   ack_only_a: assert property (@(posedge clk) disable iff (!rstn)
      !wbReq |=> !wbAck) else $error("acknowledge without request");

   // Priority control reads back what is stored
   prio_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (wbReq && !wbWe && prioHit)
      |=> wbDatR == {16'h0000, $past(r_reg.prio)})
      else $error("priority read returned wrong value");

   // Status shows the requests and the current owner
   status_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (wbReq && statHit)
      |=> wbDatR == {24'h000000, $past(mstReq), 2'h0, $past(mstGnt)})
      else $error("status read returned wrong value");

   // Unmapped offsets read as zero
   unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (wbReq && !prioHit && !statHit)
      |=> wbDatR == dmba_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   // Read data holds between requests
   rdat_held_a: assert property (@(posedge clk) disable iff (!rstn)
      !wbReq |=> $stable(wbDatR)) else $error("read data changed idle");

   // Priority only changes through a write to its own offset
   prio_kept_a: assert property (@(posedge clk) disable iff (!rstn)
      !(wbReq && wbWe && prioHit) |=> $stable(r_reg.prio))
      else $error("priority changed without a write");

   // A low-lane write leaves the high byte of the priority alone
   prio_lanes_a: assert property (@(posedge clk) disable iff (!rstn)
      (wbReq && wbWe && prioHit && wbSel[1:0] == 2'h1)
      |=> r_reg.prio == {$past(r_reg.prio[15:8]), $past(wbDatW[7:0])})
      else $error("priority lane merge wrong");

   // Reset leaves the bus free, the answer low and default priority
   reset_clear_a: assert property (@(posedge clk)
      !rstn |=> (mstGnt == 3'h0 && !wbAck && wbDatR == 32'h00000000
                 && r_reg.prio == dmba_pkg::PRIO_CTRL_RESET))
      else $error("reset state wrong");

   // ----------------------------------------------------------------
   // Arbitration checks
   // ----------------------------------------------------------------
   // A grant only ever goes to a master that was requesting
   gnt_to_req_a: assert property (@(posedge clk) disable iff (!rstn)
      r_reg.st == dmba_pkg::ARB_IDLE
      |=> (mstGnt & ~$past(mstReq)) == 3'h0)
      else $error("grant to a master without request");

   // The owner's done pulse frees the bus on the next edge
   gnt_release_a: assert property (@(posedge clk) disable iff (!rstn)
      (mstGnt != 3'h0 && (mstDone & mstGnt) != 3'h0)
      |=> mstGnt == 3'h0) else $error("grant kept after done");

   // No request, no grant
   no_req_gnt_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && mstReq == 3'h0)
      |=> mstGnt == 3'h0) else $error("grant without any request");

   // Default and reserved settings rank the core above the DMA
   core_over_dma_a: assert property (@(posedge clk)
      disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE
       && r_reg.prio != dmba_pkg::PRIO_DMA_RAISED && mstReq[1:0] == 2'h3)
      |=> mstGnt == 3'h1) else $error("dma beat core by default");

   // The raised setting ranks the DMA above the core
   dma_over_core_a: assert property (@(posedge clk)
      disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE
       && r_reg.prio == dmba_pkg::PRIO_DMA_RAISED && mstReq[1:0] == 2'h3)
      |=> mstGnt == 3'h2) else $error("core beat dma when raised");

   // The debug module master only wins when nobody else asks
   dbg_last_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_IDLE && mstReq[2] && mstReq[1:0] != 2'h0)
      |=> !mstGnt[2]) else $error("debug module master not lowest");

   // The state and the grant agree: busy exactly while someone owns
   busy_gnt_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == dmba_pkg::ARB_BUSY) == (mstGnt != 3'h0))
      else $error("state and grant disagree");

endmodule : dmba_arbiter

`default_nettype wire

/* dmba_pkg.sv */
/*
 Package for the data memory bus arbiter: register offsets, the two
 priority encodings, master indices and the arbiter state enumeration.
 Assumes a 32-bit classic Wishbone register bus on the system clock.
*/
`default_nettype none

package dmba_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0]  PRIO_CTRL_OFFSET = 4'h0;  // Priority control
   localparam logic [3:0]  STATUS_OFFSET    = 4'h4;  // Grant status
   localparam logic [15:0] PRIO_CTRL_RESET  = 16'h0000;
   localparam logic [15:0] PRIO_DEFAULT     = 16'h0000; // Core highest
   localparam logic [15:0] PRIO_DMA_RAISED  = 16'h0020; // DMA highest
   localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

   // ----------------------------------------------------------------
   // Master indices (one-hot grant bit positions)
   // ----------------------------------------------------------------
   localparam int MST_CORE  = 0;  // Processor core
   localparam int MST_DMA   = 1;  // DMA controller
   localparam int MST_DEBUG = 2;  // Debug module master
   localparam int NUM_MST   = 3;

   // Arbiter state
   typedef enum logic [1:0] {
      ARB_IDLE,
      ARB_BUSY
   } dmba_state_t;
endpackage : dmba_pkg

`default_nettype wire

/* dmba_mst_model.sv */
/*
 Behavioural model of the three data memory bus masters.
 Assumes a one-hot grant; a done pulse while granted ends an access.
*/
`timescale 1ns/1ns
`default_nettype none

module dmba_mst_model #(
   parameter int LAT = 2  // Granted cycles before done, less one
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Bench side: start one access per set bit
   input  wire logic [2:0] go,
   // Arbiter side
   input  wire logic [2:0] mstGnt,
   output var  logic [2:0] mstReq,
   output var  logic [2:0] mstDone
);
   logic [1:0] cnt [3];  // Cycles spent granted

   // Request held until done, which follows LAT+1 granted cycles
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         mstDone[i] <= 1'b0;
         if (!rstn) begin
            mstReq[i] <= 1'b0;
            cnt[i]    <= 2'h0;
         end else if (go[i]) begin
            mstReq[i] <= 1'b1;
         end else if (mstGnt[i] && mstReq[i]) begin
            cnt[i] <= cnt[i] + 2'h1;
            if (cnt[i] == 2'(LAT)) begin
               mstDone[i] <= 1'b1;
               mstReq[i]  <= 1'b0;
               cnt[i]     <= 2'h0;
            end
         end
      end
   end
endmodule : dmba_mst_model
`default_nettype wire

/* tb.sv */
/*
 Bench for the arbiter: Wishbone register access and grant order.
 Assumes the package and the master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic        clk, rstn, wbCyc, wbStb, wbWe, wbAck;
   logic [3:0]  wbAdr, wbSel;
   logic [31:0] wbDatW, wbDatR, rd;
   logic [2:0]  mstReq, mstDone, mstGnt, go, prevG;
   logic [2:0]  order [$];  // Grants in the order given
   int          failures = 0;
   int          comparisons = 0;

   dmba_arbiter u_dmba_arbiter (.clk(clk), .rstn(rstn), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .mstReq(mstReq), .mstDone(mstDone), .mstGnt(mstGnt));
   dmba_mst_model u_dmba_mst_model (.clk(clk), .rstn(rstn), .go(go),
      .mstGnt(mstGnt), .mstReq(mstReq), .mstDone(mstDone));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic mis(input string m);
      failures++;
      $display("MISMATCH %0t %s", $time, m);
   endtask : mis

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) mis($sformatf("got %h exp %h", got, exp));
   endtask : chk

   // Grant monitor: log each new grant, flag a double grant
   always @(negedge clk) begin
      if (rstn && mstGnt !== 3'h0 && mstGnt !== prevG)
         order.push_back(mstGnt);
      if ((mstGnt & (mstGnt - 3'h1)) !== 3'h0) mis("double grant");
      prevG = mstGnt;
   end

   // Classic Wishbone cycle, held until ack is sampled high at an edge
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, we, a, d};
      wbSel <= 4'h3;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1);
      rd = wbDatR;
      {wbCyc, wbStb} <= 2'h0;
      if (n != 2) mis("ack not one cycle after request");
   endtask : wb

   // All three masters request in the same cycle
   task automatic run3(input logic [8:0] exp);
      order.delete();
      @(posedge clk);
      go <= 3'h7;
      @(posedge clk);
      go <= 3'h0;
      while (order.size() < 3) @(posedge clk);
      chk(32'({order[0], order[1], order[2]}), 32'(exp));
   endtask : run3

   task automatic test_done;
      $display("Counts: %0d comparisons, %0d failures", comparisons,
               failures);
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   initial begin
      {rstn, wbCyc, wbStb, wbWe, go} = '0;
      {wbAdr, wbSel, wbDatW} = '0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, dmba_pkg::PRIO_CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      chk(rd, dmba_pkg::UNMAPPED_READ);
      wb(1'b0, dmba_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, 32'h0);
      run3({3'h1, 3'h2, 3'h4});
      $display("Test default order done");
      wb(1'b1, dmba_pkg::PRIO_CTRL_OFFSET, 32'h20);
      wb(1'b0, dmba_pkg::PRIO_CTRL_OFFSET, 32'h0);
      chk(rd, 32'h20);
      run3({3'h2, 3'h1, 3'h4});
      $display("Test raised order done");
      wb(1'b1, dmba_pkg::PRIO_CTRL_OFFSET, 32'h0);
      run3({3'h1, 3'h2, 3'h4});
      $display("Test restored order done");
      test_done;
   end

   // Watchdog well past the expected run
   initial begin
      #20000;
      mis("timeout");
      test_done;
   end
endmodule : tb
`default_nettype wire
